// File: design/rdt_top.sv
// Two-channel reload down timer with an APB register slave.
// Assumes trigger and event pins are synchronous to mclk_i.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module rdt_top #(
   parameter int NCH = 2
) (
   // Clock and reset.
   input  wire logic            mclk_i,
   input  wire logic            nrst_i,
   // APB slave.
   input  wire logic            psel_i,
   input  wire logic            penable_i,
   input  wire logic            pwrite_i,
   input  wire logic [11:0]     paddr_i,
   input  wire logic [31:0]     pwdata_i,
   output logic      [31:0]     prdata_o,
   output logic                 pready_o,
   output logic                 pslverr_o,
   // Pins.
   input  wire logic [NCH-1:0]  trig_i,
   input  wire logic [NCH-1:0]  event_i,
   // Requests.
   output logic                 irq_o,
   output logic [NCH-1:0]       ios_req_o
);
   logic [4:0]      pre_r;
   logic [2:0]      tick;
   logic [NCH-1:0]  stat_r;
   logic [NCH-1:0]  mask_r;
   logic [NCH-1:0]  ufl;
   logic [NCH-1:0]  ios_r;
   logic [31:0]     rd;
   logic            hit;
   logic            wr;
   logic            rdacc;

   // ======================================================================
   // Shared prescaler.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_r <= 5'h00;
      end else begin
         pre_r <= pre_r + 5'h01;
      end
   end
   // Each rate ticks once per period of its ratio, all from one counter.
   assign tick[0] = ((pre_r & 5'(rdt_pkg::DIV0 - 1))
                     == 5'(rdt_pkg::DIV0 - 1));
   assign tick[1] = ((pre_r & 5'(rdt_pkg::DIV1 - 1))
                     == 5'(rdt_pkg::DIV1 - 1));
   assign tick[2] = ((pre_r & 5'(rdt_pkg::DIV2 - 1))
                     == 5'(rdt_pkg::DIV2 - 1));

   assign wr    = psel_i & penable_i & pwrite_i;
   assign rdacc = psel_i & penable_i & ~pwrite_i;

   // ======================================================================
   // Channels.
   for (genvar g = 0; g < NCH; g++) begin : g_ch               // [RULE6]
      rdt_chan_if cif ();
      logic [15:0] reload_r;
      logic        en_r;
      logic        rl_r;
      logic        xt_r;
      logic [1:0]  csl_r;
      logic        sw_r;
      localparam logic [11:0] BASE = 12'(g * 16);
      always_ff @(posedge mclk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            reload_r <= rdt_pkg::RELOAD_RST;
            en_r     <= 1'b0;
            rl_r     <= 1'b0;
            xt_r     <= 1'b0;
            csl_r    <= 2'h0;
            ios_r[g] <= 1'b0;
            sw_r     <= 1'b0;
         end else begin
            sw_r <= 1'b0;
            if (wr && paddr_i == BASE + rdt_pkg::ADDR_CTRL) begin
               en_r     <= pwdata_i[rdt_pkg::CTRL_ENABLE];
               sw_r     <= pwdata_i[rdt_pkg::CTRL_SWTRIG];
               rl_r     <= pwdata_i[rdt_pkg::CTRL_RELOAD];
               xt_r     <= pwdata_i[rdt_pkg::CTRL_EXTTRIG];
               ios_r[g] <= pwdata_i[rdt_pkg::CTRL_IOS];
               csl_r    <= pwdata_i[rdt_pkg::CTRL_CSL_LO +: 2];
            end
            if (wr && paddr_i == BASE + rdt_pkg::ADDR_RELOAD) begin
               reload_r <= pwdata_i[15:0];
            end
         end
      end
      assign cif.enable      = en_r;
      assign cif.reload_mode = rl_r;
      assign cif.ext_trig_en = xt_r;
      assign cif.csl         = csl_r;
      assign cif.reload      = reload_r;
      assign cif.sw_trig     = sw_r;
      assign ufl[g]          = cif.underflow;
      rdt_channel u_ch (
         .mclk_i  (mclk_i),
         .nrst_i  (nrst_i),
         .tick_i  (tick),
         .trig_i  (trig_i[g]),
         .event_i (event_i[g]),
         .ch      (cif.chan)
      );
   end

   // ======================================================================
   // Interrupt status, mask and transfer service requests.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stat_r <= '0;
         mask_r <= '0;
      end else begin
         // A read clears only the bits it reported, and a new underflow
         // wins, so an event between setup and access is not lost.
         if (rdacc && paddr_i == rdt_pkg::ADDR_IRQ_STAT) begin
            stat_r <= (stat_r & ~prdata_o[NCH-1:0]) | ufl;
         end else begin
            stat_r <= stat_r | ufl;                             // [RULE3]
         end
         if (wr && paddr_i == rdt_pkg::ADDR_IRQ_MASK) begin
            mask_r <= pwdata_i[NCH-1:0];
         end
      end
   end
   assign irq_o     = |(stat_r & mask_r & ~ios_r);
   assign ios_req_o = stat_r & mask_r & ios_r;                 // [RULE11]

   // ======================================================================
   // Read mux.
   always_comb begin
      rd  = 32'h0000_0000;
      hit = 1'b0;
      if (paddr_i == rdt_pkg::ADDR_IRQ_STAT) begin
         rd[NCH-1:0] = stat_r;
         hit = 1'b1;
      end
      if (paddr_i == rdt_pkg::ADDR_IRQ_MASK) begin
         rd[NCH-1:0] = mask_r;
         hit = 1'b1;
      end
      for (int i = 0; i < NCH; i++) begin
         if (paddr_i == 12'(i * 16) + rdt_pkg::ADDR_CTRL) begin
            hit = 1'b1;
         end
      end
      if (paddr_i == rdt_pkg::ADDR_CTRL) begin
         rd[rdt_pkg::CTRL_ENABLE]        = g_ch[0].en_r;
         rd[rdt_pkg::CTRL_RELOAD]        = g_ch[0].rl_r;
         rd[rdt_pkg::CTRL_EXTTRIG]       = g_ch[0].xt_r;
         rd[rdt_pkg::CTRL_IOS]           = ios_r[0];
         rd[rdt_pkg::CTRL_CSL_LO +: 2]   = g_ch[0].csl_r;
         rd[rdt_pkg::CTRL_RUNNING]       = g_ch[0].cif.running;
      end
      if (paddr_i == rdt_pkg::CH_STRIDE + rdt_pkg::ADDR_CTRL) begin
         rd[rdt_pkg::CTRL_ENABLE]        = g_ch[1].en_r;
         rd[rdt_pkg::CTRL_RELOAD]        = g_ch[1].rl_r;
         rd[rdt_pkg::CTRL_EXTTRIG]       = g_ch[1].xt_r;
         rd[rdt_pkg::CTRL_IOS]           = ios_r[1];
         rd[rdt_pkg::CTRL_CSL_LO +: 2]   = g_ch[1].csl_r;
         rd[rdt_pkg::CTRL_RUNNING]       = g_ch[1].cif.running;
      end
      for (int i = 0; i < NCH; i++) begin
         if (paddr_i == 12'(i * 16) + rdt_pkg::ADDR_RELOAD) begin
            hit = 1'b1;
         end
         if (paddr_i == 12'(i * 16) + rdt_pkg::ADDR_COUNT) begin
            hit = 1'b1;
         end
      end
      if (paddr_i == rdt_pkg::ADDR_RELOAD) rd[15:0] = g_ch[0].reload_r;
      if (paddr_i == rdt_pkg::ADDR_COUNT)  rd[15:0] = g_ch[0].cif.count;
      if (paddr_i == rdt_pkg::CH_STRIDE + rdt_pkg::ADDR_RELOAD)
         rd[15:0] = g_ch[1].reload_r;
      if (paddr_i == rdt_pkg::CH_STRIDE + rdt_pkg::ADDR_COUNT)
         rd[15:0] = g_ch[1].cif.count;
   end

   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         prdata_o <= rd;
      end
   end
endmodule : rdt_top

// File: design/rdt_pkg.sv
// Constants shared by the reload down timer block.
// Assumes a single 200 MHz clock and an APB register slave.
// Notes on behaviour
// [RULE1] Each channel counts one of three internal clock rates or external event edges, chosen by software.
// [RULE2] Counting starts on a software trigger or on an external trigger edge, as software chooses.
// [RULE3] When the 16-bit counter underflows the channel can raise an interrupt request.
// [RULE4] In one-shot mode the channel stops at underflow until triggered again.
// [RULE5] In reload mode the reload value is copied into the counter at underflow and counting goes on.
// [RULE6] The block holds two independent channels.
// [RULE7] Internal clock mode accepts both triggers; event count mode accepts only the software trigger.
// [RULE8] Clock select values 00, 01 and 10 choose internal clock mode, each with its own period.
// [RULE9] In internal clock mode the counter decrements once per pulse of the selected rate.
// [RULE10] In internal clock mode activation happens on the software trigger or an external trigger edge.
// [RULE11] The underflow request can also start the intelligent I/O transfer service.
// [RULE12] Clock select value 11 chooses event count mode, decrementing on each external event edge.
// [RULE13] Each accepted trigger loads the reload value into the counter before decrementing.
package rdt_pkg;
   // ======================================================================
   // Register map, per channel stride 0x10.
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_RELOAD    = 12'h004;
   localparam logic [11:0] ADDR_COUNT     = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STAT  = 12'h040;
   localparam logic [11:0] ADDR_IRQ_MASK  = 12'h044;
   localparam logic [11:0] CH_STRIDE      = 12'h010;
   // ======================================================================
   // Control field positions.
   localparam int CTRL_ENABLE   = 0;
   localparam int CTRL_SWTRIG   = 1;
   localparam int CTRL_RELOAD   = 2;
   localparam int CTRL_EXTTRIG  = 3;
   localparam int CTRL_IOS      = 4;
   localparam int CTRL_CSL_LO   = 5;
   localparam int CTRL_RUNNING  = 8;
   localparam logic [1:0] CSL_EVENT = 2'h3;
   // ======================================================================
   // Prescaler ratios for select values 00, 01, 10.
   localparam int DIV0 = 2;
   localparam int DIV1 = 8;
   localparam int DIV2 = 32;
   localparam logic [15:0] RELOAD_RST = 16'h0000;
endpackage : rdt_pkg

// File: design/rdt_chan_if.sv
// Signals between the register slave and one timer channel.
// Assumes one clock domain.
`timescale 1ns/1ps
interface rdt_chan_if;
   logic        enable;
   logic        reload_mode;
   logic        ext_trig_en;
   logic [1:0]  csl;
   logic [15:0] reload;
   logic        sw_trig;
   logic [15:0] count;
   logic        running;
   logic        underflow;
   modport regs (output enable, reload_mode, ext_trig_en, csl, reload,
                 sw_trig, input count, running, underflow);
   modport chan (input enable, reload_mode, ext_trig_en, csl, reload,
                 sw_trig, output count, running, underflow);
endinterface : rdt_chan_if

// File: design/rdt_channel.sv
// One reload down timer channel.
// Assumes the prescaler enables are one-cycle pulses.
`timescale 1ns/1ps
module rdt_channel (
   // Clock and reset.
   input  wire logic   mclk_i,
   input  wire logic   nrst_i,
   // Prescaler ticks for select 00, 01, 10.
   input  wire logic [2:0] tick_i,
   // External pins, synchronous.
   input  wire logic   trig_i,
   input  wire logic   event_i,
   // Register side.
   rdt_chan_if.chan    ch
);
   logic trig_d_r;
   logic event_d_r;
   logic [15:0] count_r;
   logic running_r;
   logic uf_r;
   logic trig_edge;
   logic event_edge;
   logic step;
   logic start;

   assign trig_edge  = trig_i & ~trig_d_r;
   assign event_edge = event_i & ~event_d_r;
   // Event edges count only at select 11, internal ticks otherwise.
   assign step = running_r & ((ch.csl == rdt_pkg::CSL_EVENT) ? event_edge
                 : tick_i[ch.csl]);                       // [RULE1] [RULE9] [RULE12] [RULE8]
   // External trigger only counts in internal clock mode.
   assign start = ch.enable & (ch.sw_trig | (ch.ext_trig_en & trig_edge
                 & (ch.csl != rdt_pkg::CSL_EVENT)));     // [RULE2] [RULE7] [RULE10]

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         trig_d_r  <= 1'b0;
         event_d_r <= 1'b0;
      end else begin
         trig_d_r  <= trig_i;
         event_d_r <= event_i;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_r   <= 16'h0000;
         running_r <= 1'b0;
         uf_r      <= 1'b0;
      end else begin
         uf_r <= 1'b0;
         if (!ch.enable) begin
            running_r <= 1'b0;
         end else if (start) begin
            count_r   <= ch.reload;                      // [RULE13]
            running_r <= 1'b1;
         end else if (step) begin
            if (count_r == 16'h0000) begin
               uf_r <= 1'b1;                             // [RULE3]
               if (ch.reload_mode) begin
                  count_r <= ch.reload;                  // [RULE5]
               end else begin
                  count_r   <= 16'hffff;
                  running_r <= 1'b0;                     // [RULE4]
               end
            end else begin
               count_r <= count_r - 16'h0001;
            end
         end
      end
   end

   assign ch.count     = count_r;
   assign ch.running   = running_r;
   assign ch.underflow = uf_r;
endmodule : rdt_channel

// File: sim/rdt_top_properties.sv
// Checker for the register port and requests of rdt_top.
// Bound to rdt_top; sees only its ports.
`timescale 1ns/1ps
module rdt_top_properties #(
   parameter int NCH = 2
) (
   // Clock and reset.
   input wire logic           mclk_i,
   input wire logic           nrst_i,
   // APB.
   input wire logic           psel_i,
   input wire logic           penable_i,
   input wire logic           pwrite_i,
   input wire logic [11:0]    paddr_i,
   input wire logic [31:0]    pwdata_i,
   input wire logic [31:0]    prdata_o,
   input wire logic           pready_o,
   input wire logic           pslverr_o,
   // Requests.
   input wire logic           irq_o,
   input wire logic [NCH-1:0] ios_req_o
);
   // ====================
   // Address decode and bus phases.
   function automatic logic mapped(logic [11:0] a);
      return a == rdt_pkg::ADDR_IRQ_STAT || a == rdt_pkg::ADDR_IRQ_MASK ||
         (a < 12'(NCH * 16) && a[3:0] <= 4'h8 && a[1:0] == 2'h0);
   endfunction : mapped
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_acc;
      psel_i && penable_i;
   endsequence
   property p_reload_back;
      logic [15:0] d;
      (s_acc ##0 (pwrite_i && paddr_i == rdt_pkg::ADDR_RELOAD,
         d = pwdata_i[15:0])) ##[1:2]
         (s_setup ##0 (!pwrite_i && paddr_i == rdt_pkg::ADDR_RELOAD))
         |=> prdata_o[15:0] == d;
   endproperty
   // ====================
   // Assertions.
   a_ready_high: assert property (pready_o)
      else $error("pready low");
   a_err_in_access: assert property (pslverr_o |-> psel_i && penable_i)
      else $error("pslverr outside access");
   a_err_unmapped: assert property (s_acc and !mapped(paddr_i) |-> pslverr_o)
      else $error("no pslverr on unmapped access");
   a_ok_mapped: assert property (s_acc and mapped(paddr_i) |-> !pslverr_o)
      else $error("pslverr on mapped access");
   a_rd_err_zero: assert property
      (s_acc and !pwrite_i && !mapped(paddr_i) |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_stands: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
      else $error("prdata changed without setup");
   a_mask_quiet: assert property (s_acc and pwrite_i &&
      paddr_i == rdt_pkg::ADDR_IRQ_MASK && pwdata_i[NCH-1:0] == '0
      |=> !irq_o && ios_req_o == '0) else $error("request while masked");
   a_reload_back: assert property (p_reload_back)
      else $error("reload readback wrong");
endmodule : rdt_top_properties
bind rdt_top rdt_top_properties #(.NCH(NCH)) u_props (.mclk_i(mclk_i),
   .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .irq_o(irq_o), .ios_req_o(ios_req_o));

// File: sim/rdt_pin_model.sv
// External trigger and event source for two timer channels.
// Takes one-cycle requests from the bench on mclk_i.
`timescale 1ns/1ps
module rdt_pin_model (
   // Clock.
   input  wire logic       mclk_i,
   // Requests.
   input  wire logic [1:0] trig_req_i,
   input  wire logic [1:0] evt_req_i,
   // Pins.
   output logic      [1:0] trig_o = 2'h0,
   output logic      [1:0] evt_o = 2'h0
);
   logic [1:0] trig_d = 2'h0;
   logic [1:0] evt_d = 2'h0;
   // Each request makes a two-cycle high pulse with one rising edge.
   always @(posedge mclk_i) begin
      trig_d <= trig_req_i;
      evt_d  <= evt_req_i;
      trig_o <= trig_req_i | trig_d;
      evt_o  <= evt_req_i | evt_d;
   end
endmodule : rdt_pin_model

// File: sim/test_rdt_top.sv
// Self-checking bench for rdt_top.
// Drives APB and the pin model; expects rdt_pkg compiled first.
`timescale 1ns/1ps
module test_rdt_top;
   localparam logic [11:0] ST = rdt_pkg::ADDR_IRQ_STAT;
   localparam logic [11:0] RL = rdt_pkg::ADDR_RELOAD;
   localparam logic [11:0] CN = rdt_pkg::ADDR_COUNT;
   localparam logic [11:0] S1 = rdt_pkg::CH_STRIDE;
   localparam logic [11:0] CT = rdt_pkg::ADDR_CTRL;
   localparam logic [11:0] MK = rdt_pkg::ADDR_IRQ_MASK;
   logic        mclk_i = 1'b0, nrst_i = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] pa = 12'h0;
   logic [31:0] pwd = 32'h0, prd, r;
   logic        rdy, err, er, irq;
   logic [1:0]  trq = 2'h0, erq = 2'h0, trig, evt, ios;
   logic [15:0] rv;
   int          n_fail = 0, checks = 0, cyc = 0, n, d;
   always #2.5 mclk_i = ~mclk_i;
   rdt_pin_model u_pins (.mclk_i(mclk_i), .trig_req_i(trq),
      .evt_req_i(erq), .trig_o(trig), .evt_o(evt));
   rdt_top dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .trig_i(trig),
      .event_i(evt), .irq_o(irq), .ios_req_o(ios));
   task chk(input logic [63:0] g, input logic [63:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, v};
      @(posedge mclk_i);
      pen <= 1'b1;
      do @(posedge mclk_i); while (rdy !== 1'b1);
      r = prd;
      er = err;
      {psel, pen} <= 2'b00;
   endtask : apb
   task pulse(input logic t, input logic [1:0] m);
      @(posedge mclk_i);
      if (t) trq <= m;
      else erq <= m;
      @(posedge mclk_i);
      {trq, erq} <= 4'h0;
      repeat (4) @(posedge mclk_i);
   endtask : pulse
   function automatic int div(input int c);
      return c == 0 ? rdt_pkg::DIV0 : c == 1 ? rdt_pkg::DIV1 : rdt_pkg::DIV2;
   endfunction : div
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         wrap_up;
      end
   end
   initial begin
      void'($urandom(32'h3d00));
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      apb(0, RL, 0);
      chk(r, 32'(rdt_pkg::RELOAD_RST));
      apb(0, 12'h080, 0);
      chk({r, er}, 33'h1);
      apb(1, MK, 32'h3);
      $display("reset test done");
      for (int c = 0; c < 3; c++) begin
         rv = 16'($urandom_range(9, 3));
         d = div(c);
         apb(1, RL, 32'(rv));
         apb(0, RL, 32'h0);
         chk(r, 32'(rv));
         apb(1, CT, 32'h3 | 32'(c << 5));
         n = 0;
         while (irq !== 1'b1 && n < 5000) begin
            @(posedge mclk_i);
            n++;
         end
         chk(n >= rv * d && n <= (rv + 1) * d + 6, 1);
         apb(0, CN, 0);
         chk(r, 32'hffff);
         apb(0, CT, 32'h0);
         chk(r[8], 0);
         apb(0, ST, 32'h0);
         @(posedge mclk_i);
         chk({r[1:0], irq}, 3'h2);
         apb(0, ST, 0);
         chk(r, 0);
      end
      $display("internal clock test done");
      rv = 16'($urandom_range(9, 2));
      apb(1, S1 + RL, 32'(rv));
      apb(1, S1, 32'h7d);
      pulse(1, 2'h2);
      apb(0, S1, 0);
      chk(r[8], 0);
      apb(1, S1, 32'h7f);
      apb(0, S1 + CN, 0);
      chk(r, rv);
      repeat (rv) pulse(0, 2'h2);
      apb(0, S1 + CN, 0);
      chk({r, ios}, {32'h0, 2'h0});
      pulse(0, 2'h2);
      chk({ios, irq}, 3'h4);
      apb(1, MK, 32'h0);
      @(posedge mclk_i);
      chk(ios, 2'h0);
      apb(1, MK, 32'h3);
      apb(0, S1 + CN, 0);
      chk(r, rv);
      apb(0, S1, 0);
      chk(r[8], 1);
      apb(0, ST, 0);
      chk(r[1], 1);
      apb(1, S1, 0);
      $display("event count test done");
      apb(1, RL, 32'h400);
      apb(1, CT, 32'h49);
      apb(0, CT, 32'h0);
      chk(r[8], 0);
      pulse(1, 2'h1);
      apb(0, CT, 32'h0);
      chk(r[8], 1);
      apb(1, CT, 32'h0);
      $display("external trigger test done");
      wrap_up;
   end
endmodule : test_rdt_top
